// ### verilog/ufc_map.svh
// ufc_map.svh: offsets, field positions, reset values and timing for the uart feature control
// assumes: included by the design module, the checker and the bench by bare name
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH

`define UFC_OFS_LINE        8'h00
`define UFC_OFS_SYSTEM      8'h04
`define UFC_OFS_TURNAROUND  8'h08
`define UFC_OFS_STATUS      8'h0C
`define UFC_OFS_DATAPATH    8'h10

`define UFC_LINE_MULTIDROP  0
`define UFC_LINE_RX_DIS     1
`define UFC_LINE_TX_DIS     2
`define UFC_LINE_PIN_SEL    3
`define UFC_LINE_DIR_CTRL   4
`define UFC_LINE_DIR_POL    5
`define UFC_LINE_MASK       8'h3F

`define UFC_SYS_TX_EMPTY    0
`define UFC_SYS_SOFT_RST    1
`define UFC_SYS_FLOW_REMAP  2
`define UFC_SYS_WAKE_EDGE   4
`define UFC_SYS_MASK        8'h15

`define UFC_RESET_LINE      8'h00
`define UFC_RESET_SYSTEM    8'h00
`define UFC_RESET_TURN      8'h00

`define UFC_SRST_CLOCKS     4
`define UFC_CLK_MHZ         100

`endif

// ### verilog/ufc_pkg.sv
// ufc_pkg.sv: types shared by the uart feature control block
// assumes: the constants live in ufc_map.svh
package ufc_pkg;
   typedef enum logic [1:0] {
      UFC_DIR_IDLE = 2'b00,
      UFC_DIR_TX   = 2'b01,
      UFC_DIR_TURN = 2'b11
   } ufc_dir_state_t;
endpackage

// ### verilog/ufc_sync2.sv
// ufc_sync2.sv: two flip-flop synchroniser for a bus of pin levels
// assumes: inputs are asynchronous to aclk
`timescale 1ns/1ns
`default_nettype none
module ufc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q   <= '1;
         sync_out <= '1;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ### verilog/ufc_feature_ctrl.sv
// ufc_feature_ctrl.sv: advanced feature control of a one-channel uart, axi4-lite slave
// assumes: uart core supplies bit ticks and fifo status; pins arrive asynchronously
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ufc_map.svh"
module ufc_feature_ctrl
   import ufc_pkg::*;
#(
   // the soft reset counter is three bits wide, so at most 8 clocks
   parameter int SRST_CLOCKS = `UFC_SRST_CLOCKS
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        rx_pin,
   input  wire logic        cts_n_pin,
   input  wire logic        dsr_n_pin,
   input  wire logic        modem_rts,
   input  wire logic        modem_dtr,
   input  wire logic        flow_hold_rx,
   input  wire logic        tx_busy,
   input  wire logic        tx_last_bit_done,
   input  wire logic        bit_tick,
   input  wire logic        tx_fifo_empty,
   input  wire logic        tx_fifo_below_trigger,
   input  wire logic        sleep_request,
   output logic             rts_n_pin,
   output logic             dtr_n_pin,
   output logic             tx_enable,
   output logic             rx_enable,
   output logic             multidrop_mode,
   output logic             flow_stop_tx,
   output logic             modem_cts,
   output logic             modem_dsr,
   output logic             uart_reset,
   output logic             sleeping,
   output logic             tx_empty_irq
);
   localparam logic [2:0] SRST_LAST = 3'(SRST_CLOCKS - 1);

   logic [7:0]     line_q;
   logic [7:0]     sys_q;
   logic [7:0]     turn_q;
   logic [2:0]     srst_cnt_q;
   logic           srst_busy_q;
   logic [7:0]     turn_cnt_q;
   ufc_dir_state_t dir_q;
   logic           sleep_q;
   logic           rx_prev_q;
   logic           aw_held_q;
   logic           w_held_q;
   logic [7:0]     aw_addr_q;
   logic [31:0]    w_data_q;
   logic [3:0]     w_strb_q;
   logic [2:0]     pins_s;

   ufc_sync2 #(
      .W(3)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .async_in({rx_pin, cts_n_pin, dsr_n_pin}),
      .sync_out(pins_s)
   );

   wire rx_s  = pins_s[2];
   wire cts_s = pins_s[1];
   wire dsr_s = pins_s[0];

   // field decode
   wire multidrop  = line_q[`UFC_LINE_MULTIDROP];
   wire rx_dis     = line_q[`UFC_LINE_RX_DIS];
   wire tx_dis     = line_q[`UFC_LINE_TX_DIS];
   wire pin_sel    = line_q[`UFC_LINE_PIN_SEL];
   wire dir_ctrl   = line_q[`UFC_LINE_DIR_CTRL];
   wire dir_pol    = line_q[`UFC_LINE_DIR_POL];
   wire tx_empty_m = sys_q[`UFC_SYS_TX_EMPTY];
   wire flow_remap = sys_q[`UFC_SYS_FLOW_REMAP];
   wire wake_edge  = sys_q[`UFC_SYS_WAKE_EDGE];

   // write channel: address and data taken independently, then answered
   wire aw_take  = s_axi_awvalid && !aw_held_q;
   wire w_take   = s_axi_wvalid && !w_held_q;
   wire aw_have  = aw_held_q || s_axi_awvalid;
   wire w_have   = w_held_q || s_axi_wvalid;
   wire wr_fire  = aw_have && w_have && !s_axi_bvalid;
   wire [7:0]  wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
   wire [3:0]  wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
   wire wa_line  = (wr_addr == `UFC_OFS_LINE);
   wire wa_sys   = (wr_addr == `UFC_OFS_SYSTEM);
   wire wa_turn  = (wr_addr == `UFC_OFS_TURNAROUND);
   wire wa_stat  = (wr_addr == `UFC_OFS_STATUS);
   wire wa_cnt   = (wr_addr == `UFC_OFS_DATAPATH);
   wire wr_lane0 = wr_fire && wr_strb[0];
   wire wr_line  = wr_lane0 && wa_line;
   wire wr_sys   = wr_lane0 && wa_sys;
   wire wr_turn  = wr_lane0 && wa_turn;
   // read-only words answer okay and keep their contents
   wire wr_known = wa_line || wa_sys || wa_turn || wa_stat || wa_cnt;
   wire srst_start = wr_sys && wr_data[`UFC_SYS_SOFT_RST];

   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q    <= 1'b0;
         w_held_q     <= 1'b0;
         aw_addr_q    <= 8'h00;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         if (wr_fire) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
         end else begin
            if (aw_take && !s_axi_bvalid) begin
               aw_held_q <= 1'b1;
               aw_addr_q <= s_axi_awaddr;
            end
            if (w_take && !s_axi_bvalid) begin
               w_held_q <= 1'b1;
               w_data_q <= s_axi_wdata;
               w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
            end
         end
      end
   end

   // soft reset: pulse of fixed length, the bit reads one until done
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         srst_busy_q <= 1'b0;
         srst_cnt_q  <= 3'd0;
      end else if (srst_start && !srst_busy_q) begin
         srst_busy_q <= 1'b1;
         srst_cnt_q  <= 3'd0;
      end else if (srst_busy_q) begin
         srst_cnt_q <= srst_cnt_q + 3'd1;
         if (srst_cnt_q == SRST_LAST) begin
            srst_busy_q <= 1'b0;
         end
      end
   end
   assign uart_reset = srst_busy_q;

   // configuration registers; the soft reset clears them like a pin reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_q <= `UFC_RESET_LINE;
         sys_q  <= `UFC_RESET_SYSTEM;
         turn_q <= `UFC_RESET_TURN;
      end else if (srst_busy_q) begin
         line_q <= `UFC_RESET_LINE;
         sys_q  <= `UFC_RESET_SYSTEM;
         turn_q <= `UFC_RESET_TURN;
      end else begin
         if (wr_line) begin
            line_q <= wr_data[7:0] & `UFC_LINE_MASK;
         end
         if (wr_sys) begin
            sys_q <= wr_data[7:0] & `UFC_SYS_MASK;
         end
         if (wr_turn) begin
            turn_q <= wr_data[7:0];
         end
      end
   end

   // read channel
   wire [7:0] sys_rd = sys_q | {6'b0, srst_busy_q, 1'b0};
   wire [7:0] status_rd = {1'b0, dir_q == UFC_DIR_TURN, dir_q == UFC_DIR_TX,
                           sleep_q, rx_s, tx_empty_irq, tx_enable, rx_enable};
   wire ra_line  = (s_axi_araddr == `UFC_OFS_LINE);
   wire ra_sys   = (s_axi_araddr == `UFC_OFS_SYSTEM);
   wire ra_turn  = (s_axi_araddr == `UFC_OFS_TURNAROUND);
   wire ra_stat  = (s_axi_araddr == `UFC_OFS_STATUS);
   wire ra_cnt   = (s_axi_araddr == `UFC_OFS_DATAPATH);
   wire [7:0] rd_mux =
      ra_line ? line_q :
      ra_sys  ? sys_rd :
      ra_turn ? turn_q :
      ra_stat ? status_rd :
      ra_cnt  ? turn_cnt_q : 8'h00;
   wire rd_known = ra_line || ra_sys || ra_turn || ra_stat || ra_cnt;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_mux};
         s_axi_rresp  <= rd_known ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // direction sequencer: transmit, then count bit times, then receive
   wire auto_dir = multidrop && dir_ctrl;
   always_ff @(posedge aclk) begin
      if (!aresetn || srst_busy_q) begin
         dir_q      <= UFC_DIR_IDLE;
         turn_cnt_q <= 8'h00;
      end else begin
         case (dir_q)
            UFC_DIR_IDLE: begin
               if (auto_dir && tx_busy) begin
                  dir_q <= UFC_DIR_TX;
               end
            end
            UFC_DIR_TX: begin
               if (tx_last_bit_done) begin
                  dir_q      <= UFC_DIR_TURN;
                  turn_cnt_q <= turn_q;
               end
            end
            UFC_DIR_TURN: begin
               if (tx_busy) begin
                  dir_q <= UFC_DIR_TX;
               end else if (turn_cnt_q == 8'h00) begin
                  dir_q <= UFC_DIR_IDLE;
               end else if (bit_tick) begin
                  turn_cnt_q <= turn_cnt_q - 8'h01;
               end
            end
            default: dir_q <= UFC_DIR_IDLE;
         endcase
      end
   end

   wire dir_transmit = (dir_q != UFC_DIR_IDLE);
   wire dir_level    = dir_transmit ? dir_pol : !dir_pol;
   wire drive_rts    = auto_dir && !pin_sel;
   wire drive_dtr    = auto_dir && pin_sel;

   // hardware flow output follows the selected pair
   wire flow_out_n = flow_hold_rx;
   wire rts_d = drive_rts ? dir_level :
                (!flow_remap && flow_hold_rx) ? flow_out_n : !modem_rts;
   wire dtr_d = drive_dtr ? dir_level :
                (flow_remap && flow_hold_rx) ? flow_out_n : !modem_dtr;

   // wake detection on synchronised rx
   wire rx_toggled = rx_s != rx_prev_q;
   wire wake_now   = wake_edge ? rx_toggled : !rx_s;
   wire may_sleep  = wake_edge || rx_s;

   // edge history follows rx through a soft reset, so no false toggle follows it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= rx_s;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || srst_busy_q) begin
         rts_n_pin    <= 1'b1;
         dtr_n_pin    <= 1'b1;
         flow_stop_tx <= 1'b0;
         modem_cts    <= 1'b0;
         modem_dsr    <= 1'b0;
      end else begin
         rts_n_pin    <= rts_d;
         dtr_n_pin    <= dtr_d;
         flow_stop_tx <= flow_remap ? dsr_s : cts_s;
         modem_cts    <= !cts_s;
         modem_dsr    <= !dsr_s;
      end
   end

   // sleep: entered on request when rx_s is high or wake_edge is set, left on wake or when the request drops
   always_ff @(posedge aclk) begin
      if (!aresetn || srst_busy_q) begin
         sleep_q <= 1'b0;
      end else if (sleep_q) begin
         if (wake_now || !sleep_request) begin
            sleep_q <= 1'b0;
         end
      end else if (sleep_request && may_sleep) begin
         sleep_q <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || srst_busy_q) begin
         tx_empty_irq <= 1'b0;
      end else begin
         tx_empty_irq <= tx_fifo_below_trigger ||
                         (tx_fifo_empty && (!tx_empty_m || !tx_busy));
      end
   end

   assign sleeping       = sleep_q;
   assign tx_enable      = !tx_dis && !srst_busy_q;
   assign rx_enable      = !rx_dis && !srst_busy_q;
   assign multidrop_mode = multidrop;
endmodule
`default_nettype wire

// ### tb/ufc_line_model.sv
// ufc_line_model.sv: line transceiver facing the uart pins
// assumes: bench sets the far-end line levels just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module ufc_line_model (
   input  wire logic rx_lvl,
   input  wire logic cts_lvl,
   input  wire logic dsr_lvl,
   output logic      rx_pin,
   output logic      cts_n_pin,
   output logic      dsr_n_pin
);
   // receiver outputs follow the far end with no delay of their own
   assign rx_pin    = rx_lvl;
   assign cts_n_pin = cts_lvl;
   assign dsr_n_pin = dsr_lvl;
endmodule
`default_nettype wire

// ### tb/ufc_feature_ctrl_checker.sv
// ufc_feature_ctrl_checker.sv: port assertions for the uart feature control
// assumes: bound to every ufc_feature_ctrl instance, one clock domain
`timescale 1ns/1ns
`default_nettype none
`include "ufc_map.svh"
module ufc_feature_ctrl_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_bvalid,
   input wire logic        rx_pin,
   input wire logic        cts_n_pin,
   input wire logic        dsr_n_pin,
   input wire logic        modem_cts,
   input wire logic        modem_dsr,
   input wire logic        sleep_request,
   input wire logic        sleeping,
   input wire logic        uart_reset,
   input wire logic        tx_enable,
   input wire logic        rx_enable,
   input wire logic        tx_fifo_empty,
   input wire logic        tx_fifo_below_trigger,
   input wire logic        tx_empty_irq
);
   logic [7:0] ar_q;
   logic [2:0] up_q;
   // up_q: cycles since any reset, so pipelines are known to be filled
   always_ff @(posedge aclk) begin
      if (!aresetn || uart_reset) up_q <= 3'h0;
      else if (up_q != 3'h7) up_q <= up_q + 3'h1;
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   srst_len_a: assert property ($rose(uart_reset) |-> uart_reset[*4] ##1 !uart_reset)
      else $error("soft reset length wrong");
   srst_cause_a: assert property ($rose(uart_reset) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("soft reset without write");
   srst_gate_a: assert property (uart_reset |-> !tx_enable && !rx_enable)
      else $error("uart runs during soft reset");
   cts_track_a: assert property (up_q == 3'h7 && $stable(cts_n_pin) &&
      $past(cts_n_pin, 2) == cts_n_pin && $past(cts_n_pin, 3) == cts_n_pin |->
      modem_cts == !cts_n_pin) else $error("modem cts lost");
   dsr_track_a: assert property (up_q == 3'h7 && $stable(dsr_n_pin) &&
      $past(dsr_n_pin, 2) == dsr_n_pin && $past(dsr_n_pin, 3) == dsr_n_pin |->
      modem_dsr == !dsr_n_pin) else $error("modem dsr lost");
   sleep_cause_a: assert property ($rose(sleeping) |-> $past(sleep_request))
      else $error("sleep without request");
   wake_fall_a: assert property (sleeping && $fell(rx_pin) |-> ##[1:5] !sleeping)
      else $error("no wake on rx fall");
   irq_below_a: assert property (up_q != 3'h0 &&
      $past(tx_fifo_below_trigger) |-> tx_empty_irq) else $error("below trigger without irq");
   irq_cause_a: assert property (tx_empty_irq |->
      $past(tx_fifo_below_trigger) || $past(tx_fifo_empty)) else $error("irq without cause");
   rsvd_line_a: assert property (s_axi_rvalid && ar_q == `UFC_OFS_LINE |->
      s_axi_rdata[31:6] == 26'h000_0000) else $error("line reserved bits set");
   rsvd_sys_a: assert property (s_axi_rvalid && ar_q == `UFC_OFS_SYSTEM |->
      s_axi_rdata[31:5] == 27'h000_0000 && !s_axi_rdata[3]) else $error("sys reserved set");
   cover property ($rose(uart_reset));
   cover property (sleeping ##1 !sleeping);
   cover property ($rose(tx_empty_irq));
endmodule
bind ufc_feature_ctrl ufc_feature_ctrl_checker chk_i (.aclk, .aresetn, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid, .rx_pin,
   .cts_n_pin, .dsr_n_pin, .modem_cts, .modem_dsr, .sleep_request, .sleeping, .uart_reset,
   .tx_enable, .rx_enable, .tx_fifo_empty, .tx_fifo_below_trigger, .tx_empty_irq);
`default_nettype wire

// ### tb/ufc_feature_ctrl_tb.sv
// ufc_feature_ctrl_tb.sv: self-checking bench for the uart feature control
// assumes: line model on the pins, checker bound from its own file
`timescale 1ns/1ns
`default_nettype none
`include "ufc_map.svh"
module ufc_feature_ctrl_tb;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, modem_rts = 1'h0;
   logic modem_dtr = 1'h0, flow_hold_rx = 1'h0, tx_busy = 1'h0, tx_last_bit_done = 1'h0;
   logic bit_tick = 1'h0, tx_fifo_empty = 1'h0, tx_fifo_below_trigger = 1'h0;
   logic sleep_request = 1'h0, rx_lvl = 1'h1, cts_lvl = 1'h1, dsr_lvl = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v;
   logic [31:0] s_axi_wdata = 32'h0000_0000, seed = 32'h0000_3c63, d, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] r, s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_pin;
   logic cts_n_pin, dsr_n_pin, rts_n_pin, dtr_n_pin, tx_enable, rx_enable, multidrop_mode;
   logic flow_stop_tx, modem_cts, modem_dsr, uart_reset, sleeping, tx_empty_irq;
   int num_errors = 0, comparisons = 0, rst_cnt = 0, i;
   always #5 aclk = ~aclk;
   always @(posedge aclk) if (uart_reset === 1'h1) rst_cnt++;
   ufc_feature_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_pin, .cts_n_pin, .dsr_n_pin,
      .modem_rts, .modem_dtr, .flow_hold_rx, .tx_busy, .tx_last_bit_done, .bit_tick,
      .tx_fifo_empty, .tx_fifo_below_trigger, .sleep_request, .rts_n_pin, .dtr_n_pin,
      .tx_enable, .rx_enable, .multidrop_mode, .flow_stop_tx, .modem_cts, .modem_dsr,
      .uart_reset, .sleeping, .tx_empty_irq);
   ufc_line_model line_i (.rx_lvl, .cts_lvl, .dsr_lvl, .rx_pin, .cts_n_pin, .dsr_n_pin);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic dir_lvl(input logic pol, input logic tx);
      return tx ? pol : !pol;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] val);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, val};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic settle();
      repeat (6) @(posedge aclk);
   endtask
   task automatic tick();
      bit_tick <= 1'h1;
      @(posedge aclk);
      bit_tick <= 1'h0;
      settle();
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      for (i = 0; i < 8; i++) begin
         d = rnd();
         v = d[7:0];
         wr(`UFC_OFS_LINE, v);
         rd(`UFC_OFS_LINE);
         chk(d, {24'h00_0000, v & `UFC_LINE_MASK});
         chk({multidrop_mode, tx_enable, rx_enable}, {v[0], !v[2], !v[1]});
         d = rnd();
         v = d[7:0] & 8'hfd;
         wr(`UFC_OFS_SYSTEM, v);
         rd(`UFC_OFS_SYSTEM);
         chk(d, {24'h00_0000, v & `UFC_SYS_MASK});
      end
      wr(8'h20, 8'hff);
      chk(r, 2'h2);
      rd(8'h20);
      chk(r, 2'h2);
      wr(`UFC_OFS_SYSTEM, 8'h00);
      wr(`UFC_OFS_TURNAROUND, 8'h02);
      rd(`UFC_OFS_TURNAROUND);
      chk(d, 32'h0000_0002);
      for (i = 0; i < 4; i++) begin
         wr(`UFC_OFS_LINE, {2'h0, i[1], 1'h1, i[0], 3'h1});
         tx_busy <= 1'h1;
         settle();
         chk(i[0] ? dtr_n_pin : rts_n_pin, dir_lvl(i[1], 1'h1));
         chk(i[0] ? rts_n_pin : dtr_n_pin, 1'h1);
         tx_busy <= 1'h0;
         tx_last_bit_done <= 1'h1;
         @(posedge aclk);
         tx_last_bit_done <= 1'h0;
         tick();
         chk(i[0] ? dtr_n_pin : rts_n_pin, dir_lvl(i[1], 1'h1));
         rd(`UFC_OFS_DATAPATH);
         chk(d, 32'h0000_0001);
         tick();
         chk(i[0] ? dtr_n_pin : rts_n_pin, dir_lvl(i[1], 1'h0));
      end
      wr(`UFC_OFS_LINE, 8'h01);
      tx_busy <= 1'h1;
      settle();
      chk(rts_n_pin, 1'h1);
      tx_busy <= 1'h0;
      wr(`UFC_OFS_LINE, 8'h00);
      modem_rts <= 1'h1;
      modem_dtr <= 1'h1;
      flow_hold_rx <= 1'h1;
      cts_lvl <= 1'h0;
      for (i = 0; i < 2; i++) begin
         wr(`UFC_OFS_SYSTEM, {5'h00, i[0], 2'h0});
         settle();
         chk({flow_stop_tx, modem_cts, modem_dsr}, {i[0], 2'h2});
         chk({rts_n_pin, dtr_n_pin}, {!i[0], i[0]});
      end
      wr(`UFC_OFS_SYSTEM, 8'h00);
      rx_lvl <= 1'h0;
      settle();
      sleep_request <= 1'h1;
      settle();
      chk(sleeping, 1'h0);
      rx_lvl <= 1'h1;
      settle();
      chk(sleeping, 1'h1);
      rx_lvl <= 1'h0;
      settle();
      chk(sleeping, 1'h0);
      wr(`UFC_OFS_SYSTEM, 8'h10);
      settle();
      chk(sleeping, 1'h1);
      rx_lvl <= 1'h1;
      d = 32'h0000_0000;
      repeat (8) begin
         @(posedge aclk);
         if (sleeping === 1'h0) d = 32'h0000_0001;
      end
      chk(d, 32'h0000_0001);
      sleep_request <= 1'h0;
      tx_fifo_empty <= 1'h1;
      tx_busy <= 1'h1;
      settle();
      chk(tx_empty_irq, 1'h1);
      wr(`UFC_OFS_SYSTEM, 8'h01);
      settle();
      chk(tx_empty_irq, 1'h0);
      tx_fifo_below_trigger <= 1'h1;
      settle();
      chk(tx_empty_irq, 1'h1);
      tx_fifo_below_trigger <= 1'h0;
      tx_busy <= 1'h0;
      settle();
      chk(tx_empty_irq, 1'h1);
      wr(`UFC_OFS_LINE, 8'h3f);
      wr(`UFC_OFS_SYSTEM, 8'h06);
      settle();
      chk(rst_cnt, 4);
      chk({tx_enable, rx_enable}, 2'h3);
      rd(`UFC_OFS_SYSTEM);
      chk(d, 32'h0000_0000);
      end_sim();
   end
endmodule
`default_nettype wire
